// [core/pid_pkg.sv]
// Constants, field layouts and carrier types for the process slot and coprocessor access block.
//
// Behaviour
// R01 - Zero top seven VA bits take slot value
// R02 - Nonzero top bits pass address unchanged
// R03 - Substitute before cache and TLB lookups
// R04 - All user addresses eligible for substitution
// R05 - Slot register at CRn 13, op2 0, CRm 0
// R06 - Branch buffer lookup uses raw address
// R07 - Slot write invalidates whole branch buffer
// R08 - Software writes breakpoints as modified addresses
// R09 - Instruction breakpoints at CRn 14, CRm 8, 9
// R10 - Data breakpoint registers at CRm 0, 3, 4
// R11 - Permission register at CRn 15, op2 0, CRm 1
// R12 - Coprocessors 14, 15 need privileged mode only
// R13 - Clear permission bit makes access undefined
// R14 - Permission bits 31:14 ignore writes, read zero
// R15 - Writes act after sync point; reset zero (breakpoint register writes here act on the next clock, with no sync point)
package pid_pkg;
    localparam int VA_W = 32;
    localparam int SLOT_W = 7;
    localparam int SLOT_LSB = 25;
    localparam int PERM_W = 14;
    localparam int BRK_N = 5;
    localparam int BRK_IDX_W = 3;

    localparam logic [3:0] CP_SYS = 4'hf;
    localparam logic [3:0] CP_DBG = 4'he;
    localparam logic [3:0] CP_LAST_GATED = 4'hd;
    localparam logic [3:0] CRN_SLOT = 4'hd;
    localparam logic [3:0] CRN_BREAK = 4'he;
    localparam logic [3:0] CRN_PERM = 4'hf;
    localparam logic [2:0] OP2_ZERO = 3'h0;
    localparam logic [3:0] CRM_SLOT = 4'h0;
    localparam logic [3:0] CRM_PERM = 4'h1;
    localparam logic [3:0] CRM_IBRK0 = 4'h8;
    localparam logic [3:0] CRM_IBRK1 = 4'h9;
    localparam logic [3:0] CRM_DBRK_ADDR = 4'h0;
    localparam logic [3:0] CRM_DBRK_MASK = 4'h3;
    localparam logic [3:0] CRM_DBRK_CTRL = 4'h4;

    localparam logic [BRK_IDX_W-1:0] BRK_I0 = 3'h0;
    localparam logic [BRK_IDX_W-1:0] BRK_I1 = 3'h1;
    localparam logic [BRK_IDX_W-1:0] BRK_DA = 3'h2;
    localparam logic [BRK_IDX_W-1:0] BRK_DM = 3'h3;
    localparam logic [BRK_IDX_W-1:0] BRK_DC = 3'h4;

    localparam logic [SLOT_W-1:0] SLOT_RESET = 7'h00;
    localparam logic [PERM_W-1:0] PERM_RESET = 14'h0000;
    localparam logic [VA_W-1:0] WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic privileged;
        logic [3:0] cp_num;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opcode_2;
        logic [VA_W-1:0] wdata;
    } cp_req_t;

    typedef struct packed {
        logic done;
        logic undef;
        logic grant;
        logic [VA_W-1:0] rdata;
    } cp_resp_t;

    typedef struct packed {
        logic [VA_W-1:0] instr_break_zero;
        logic [VA_W-1:0] instr_break_one;
        logic [VA_W-1:0] data_break_addr;
        logic [VA_W-1:0] data_break_mask_addr;
        logic [VA_W-1:0] data_break_control;
    } break_regs_t;
endpackage : pid_pkg

// [core/addr_slot_remap.sv]
// Registered process slot substitution for one virtual address stream.
`timescale 1ns/1ps
module addr_slot_remap #(
    parameter int VA_W = 32,
    parameter int SLOT_W = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Address in, slot value, modified address out
    input wire logic [VA_W-1:0] va,
    input wire logic [SLOT_W-1:0] slot,
    output logic [VA_W-1:0] mod_addr_reg
);
    logic [VA_W-1:0] mod_addr_next;
    logic top_zero;

    assign top_zero = (va[VA_W-1 -: SLOT_W] == '0);

    always_comb begin
        mod_addr_next = va; // see R02
        if (top_zero) begin
            mod_addr_next = {slot, va[VA_W-SLOT_W-1:0]}; // see R01
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mod_addr_reg <= '0;
        end else begin
            mod_addr_reg <= mod_addr_next;
        end
    end
endmodule : addr_slot_remap

// [core/pid_remap_and_coproc_access.sv]
// Process slot remap, breakpoint register bank and coprocessor permission gate.
`timescale 1ns/1ps
module pid_remap_and_coproc_access (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Coprocessor move requests from the core
    input pid_pkg::cp_req_t req,
    output pid_pkg::cp_resp_t resp,
    // Pipeline synchronisation point
    input wire logic sync_point,
    // Address streams before cache and TLB lookup
    input wire logic [pid_pkg::VA_W-1:0] instr_va,
    input wire logic [pid_pkg::VA_W-1:0] data_va,
    output logic [pid_pkg::VA_W-1:0] instr_mod_addr,
    output logic [pid_pkg::VA_W-1:0] data_mod_addr,
    // Branch target buffer side
    output logic [pid_pkg::VA_W-1:0] branch_buf_addr,
    output logic branch_buf_flush,
    // Register contents for the rest of the core
    output pid_pkg::break_regs_t break_regs,
    output logic [pid_pkg::PERM_W-1:0] perm_active
);
    logic [pid_pkg::SLOT_W-1:0] slot_staged_reg;
    logic [pid_pkg::SLOT_W-1:0] slot_active_reg;
    logic [pid_pkg::PERM_W-1:0] perm_staged_reg;
    logic [pid_pkg::PERM_W-1:0] perm_active_reg;
    logic [pid_pkg::VA_W-1:0] break_reg [pid_pkg::BRK_N];
    logic [pid_pkg::VA_W-1:0] branch_buf_addr_reg;
    logic branch_buf_flush_reg;
    pid_pkg::cp_resp_t resp_reg;
    pid_pkg::cp_resp_t resp_next;

    logic is_sys;
    logic is_dbg;
    logic is_gated;
    logic sel_slot;
    logic sel_perm;
    logic sel_brk;
    logic brk_hit;
    logic [pid_pkg::BRK_IDX_W-1:0] brk_idx;
    logic deny;
    logic accept;
    logic wr_slot;

    // Decode of the coprocessor move fields.
    assign is_sys = (req.cp_num == pid_pkg::CP_SYS);
    assign is_dbg = (req.cp_num == pid_pkg::CP_DBG);
    assign is_gated = (req.cp_num <= pid_pkg::CP_LAST_GATED);
    assign sel_slot = is_sys && (req.crn == pid_pkg::CRN_SLOT)
                      && (req.opcode_2 == pid_pkg::OP2_ZERO)
                      && (req.crm == pid_pkg::CRM_SLOT); // see R05
    assign sel_perm = is_sys && (req.crn == pid_pkg::CRN_PERM)
                      && (req.opcode_2 == pid_pkg::OP2_ZERO)
                      && (req.crm == pid_pkg::CRM_PERM); // see R11
    assign sel_brk = is_sys && (req.crn == pid_pkg::CRN_BREAK)
                     && (req.opcode_2 == pid_pkg::OP2_ZERO) && brk_hit;

    always_comb begin
        brk_hit = 1'b1;
        brk_idx = pid_pkg::BRK_I0;
        case (req.crm)
            pid_pkg::CRM_IBRK0: brk_idx = pid_pkg::BRK_I0; // see R09
            pid_pkg::CRM_IBRK1: brk_idx = pid_pkg::BRK_I1; // see R09
            pid_pkg::CRM_DBRK_ADDR: brk_idx = pid_pkg::BRK_DA; // see R10
            pid_pkg::CRM_DBRK_MASK: brk_idx = pid_pkg::BRK_DM; // see R10
            pid_pkg::CRM_DBRK_CTRL: brk_idx = pid_pkg::BRK_DC; // see R10
            default: brk_hit = 1'b0;
        endcase
    end

    // The system and debug coprocessors ignore the permission bits entirely.
    always_comb begin
        deny = 1'b0;
        if ((is_sys || is_dbg) && !req.privileged) begin
            deny = 1'b1; // see R12
        end else if (is_gated && !perm_active_reg[req.cp_num]) begin
            deny = 1'b1; // see R13
        end
    end

    assign accept = req.valid && !deny;
    assign wr_slot = accept && req.write && sel_slot;

    // Answer: one cycle after the request, reads carry the staged values.
    always_comb begin
        resp_next = '0;
        resp_next.done = req.valid;
        resp_next.undef = req.valid && deny; // see R13
        resp_next.grant = accept && is_gated;
        if (accept && !req.write) begin
            if (sel_slot) begin
                resp_next.rdata = {slot_staged_reg, {pid_pkg::SLOT_LSB{1'b0}}};
            end else if (sel_perm) begin
                resp_next.rdata = {{(pid_pkg::VA_W-pid_pkg::PERM_W){1'b0}},
                                   perm_staged_reg}; // see R14
            end else if (sel_brk) begin
                resp_next.rdata = break_reg[brk_idx];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            resp_reg <= '0;
        end else begin
            resp_reg <= resp_next;
        end
    end

    // Staged copies hold what software wrote; reserved slot bits are dropped.
    always_ff @(posedge clk) begin
        if (reset) begin
            slot_staged_reg <= pid_pkg::SLOT_RESET; // see R15
        end else if (wr_slot) begin
            slot_staged_reg <= req.wdata[pid_pkg::VA_W-1 -: pid_pkg::SLOT_W];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            perm_staged_reg <= pid_pkg::PERM_RESET; // see R15
        end else if (accept && req.write && sel_perm) begin
            perm_staged_reg <= req.wdata[pid_pkg::PERM_W-1:0]; // see R14
        end
    end

    // The live copies change only at a synchronisation point, so instructions
    // already in flight keep the old mapping and permissions. A write in the
    // same cycle as the sync pulse waits for the next one.
    always_ff @(posedge clk) begin
        if (reset) begin
            slot_active_reg <= pid_pkg::SLOT_RESET;
            perm_active_reg <= pid_pkg::PERM_RESET;
        end else if (sync_point) begin
            slot_active_reg <= slot_staged_reg; // see R15
            perm_active_reg <= perm_staged_reg; // see R15
        end
    end

    // Breakpoint values are stored as written; software already merged the slot.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < pid_pkg::BRK_N; i++) begin
                break_reg[i] <= pid_pkg::WORD_ZERO;
            end
        end else if (accept && req.write && sel_brk) begin
            break_reg[brk_idx] <= req.wdata; // see R08
        end
    end

    // Flush on every slot write, even one of the same value.
    always_ff @(posedge clk) begin
        if (reset) begin
            branch_buf_flush_reg <= 1'b0;
        end else begin
            branch_buf_flush_reg <= wr_slot; // see R07
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            branch_buf_addr_reg <= pid_pkg::WORD_ZERO;
        end else begin
            branch_buf_addr_reg <= instr_va; // see R06
        end
    end

    // Both streams are remapped with one cycle of latency ahead of lookup.
    addr_slot_remap #(
        .VA_W(pid_pkg::VA_W),
        .SLOT_W(pid_pkg::SLOT_W)
    ) u_instr_remap (
        .clk(clk),
        .reset(reset),
        .va(instr_va),
        .slot(slot_active_reg),
        .mod_addr_reg(instr_mod_addr)
    ); // see R03

    addr_slot_remap #(
        .VA_W(pid_pkg::VA_W),
        .SLOT_W(pid_pkg::SLOT_W)
    ) u_data_remap (
        .clk(clk),
        .reset(reset),
        .va(data_va),
        .slot(slot_active_reg),
        .mod_addr_reg(data_mod_addr)
    ); // see R03, R04

    assign resp = resp_reg;
    assign branch_buf_addr = branch_buf_addr_reg;
    assign branch_buf_flush = branch_buf_flush_reg;
    assign perm_active = perm_active_reg;
    // One assignment for the whole carrier keeps the output to a single driver.
    assign break_regs = {break_reg[pid_pkg::BRK_I0], break_reg[pid_pkg::BRK_I1],
                         break_reg[pid_pkg::BRK_DA], break_reg[pid_pkg::BRK_DM],
                         break_reg[pid_pkg::BRK_DC]};

    // Address path checks.
    a_slot_subst: assert property (@(posedge clk) disable iff (reset) // see R01
        (data_va[pid_pkg::VA_W-1 -: pid_pkg::SLOT_W] == '0)
        |=> (data_mod_addr[pid_pkg::VA_W-1 -: pid_pkg::SLOT_W] == $past(slot_active_reg)))
        else $error("data address top bits not replaced by slot");

    a_instr_subst: assert property (@(posedge clk) disable iff (reset) // see R04
        (instr_va[pid_pkg::VA_W-1 -: pid_pkg::SLOT_W] == '0)
        |=> (instr_mod_addr == {$past(slot_active_reg),
                                $past(instr_va[pid_pkg::SLOT_LSB-1:0])}))
        else $error("instruction address not remapped with slot");

    a_no_subst: assert property (@(posedge clk) disable iff (reset) // see R02
        (instr_va[pid_pkg::VA_W-1 -: pid_pkg::SLOT_W] != '0)
        |=> (instr_mod_addr == $past(instr_va)))
        else $error("address with nonzero top bits was changed");

    a_data_pass: assert property (@(posedge clk) disable iff (reset) // see R02
        (data_va[pid_pkg::VA_W-1 -: pid_pkg::SLOT_W] != '0)
        |=> (data_mod_addr == $past(data_va)))
        else $error("data address with nonzero top bits was changed");

    a_branch_raw: assert property (@(posedge clk) disable iff (reset) // see R06
        (slot_active_reg != pid_pkg::SLOT_RESET) |=> (branch_buf_addr == $past(instr_va)))
        else $error("branch buffer address was remapped");

    // Branch buffer flush checks.
    a_flush_on_write: assert property (@(posedge clk) disable iff (reset) // see R07
        wr_slot |=> branch_buf_flush ##1 (!branch_buf_flush || $past(wr_slot)))
        else $error("slot write did not pulse branch buffer flush");

    a_flush_cause: assert property (@(posedge clk) disable iff (reset) // see R07
        branch_buf_flush |-> $past(wr_slot))
        else $error("branch buffer flushed without slot write");

    // Move port answer checks.
    a_perm_deny: assert property (@(posedge clk) disable iff (reset) // see R13
        (req.valid && is_gated && !perm_active_reg[req.cp_num])
        |=> (resp.done && resp.undef && !resp.grant))
        else $error("denied coprocessor access not made undefined");

    a_perm_grant: assert property (@(posedge clk) disable iff (reset) // see R13
        (req.valid && is_gated && perm_active_reg[req.cp_num])
        |=> (resp.done && resp.grant && !resp.undef))
        else $error("permitted coprocessor access was refused");

    a_grant_gated: assert property (@(posedge clk) disable iff (reset) // see R13
        resp.grant |-> ($past(req.cp_num) <= pid_pkg::CP_LAST_GATED))
        else $error("grant given to an ungated coprocessor");

    a_priv_only: assert property (@(posedge clk) disable iff (reset) // see R12
        (req.valid && (is_sys || is_dbg))
        |=> (resp.undef == !$past(req.privileged)))
        else $error("system coprocessor privilege check wrong");

    a_resp_idle: assert property (@(posedge clk) disable iff (reset) // see R13
        !req.valid |=> (resp == '0))
        else $error("answer given without a request");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (reset) // see R11
        (req.valid && (is_sys || is_dbg) && !sel_slot && !sel_perm && !sel_brk)
        |=> (resp.rdata == '0))
        else $error("unmapped selection returned data");

    a_slot_read: assert property (@(posedge clk) disable iff (reset) // see R05
        (accept && !req.write && sel_slot)
        |=> (resp.rdata == {$past(slot_staged_reg), {pid_pkg::SLOT_LSB{1'b0}}}))
        else $error("slot register read returned wrong value");

    a_perm_rsvd: assert property (@(posedge clk) disable iff (reset) // see R14
        (req.valid && !deny && !req.write && sel_perm)
        |=> (resp.rdata[pid_pkg::VA_W-1:pid_pkg::PERM_W] == '0))
        else $error("reserved permission bits read nonzero");

    a_perm_store: assert property (@(posedge clk) disable iff (reset) // see R14
        (accept && req.write && sel_perm)
        |=> (perm_staged_reg == $past(req.wdata[pid_pkg::PERM_W-1:0])))
        else $error("permission write not stored");

    a_deny_no_store: assert property (@(posedge clk) disable iff (reset) // see R12
        (req.valid && deny && req.write)
        |=> ($stable(slot_staged_reg) && $stable(perm_staged_reg)))
        else $error("refused write changed a register");

    // Staged and live copies.
    a_sync_effect: assert property (@(posedge clk) disable iff (reset) // see R15
        (wr_slot && !sync_point) ##1 sync_point
        |=> (slot_active_reg == $past(slot_staged_reg, 1)))
        else $error("slot write did not take effect at sync point");

    a_sync_hold: assert property (@(posedge clk) disable iff (reset) // see R15
        !sync_point |=> ($stable(slot_active_reg) && $stable(perm_active_reg)))
        else $error("live copy changed without sync point");

    a_reset_zero: assert property (@(posedge clk) // see R15
        $past(reset) |-> (slot_active_reg == pid_pkg::SLOT_RESET
                          && perm_active_reg == pid_pkg::PERM_RESET
                          && !branch_buf_flush_reg))
        else $error("register not zero after reset");

    a_brk_store: assert property (@(posedge clk) disable iff (reset) // see R09 R10
        (accept && req.write && sel_brk)
        |=> (break_reg[$past(brk_idx)] == $past(req.wdata)))
        else $error("breakpoint register did not store write");
endmodule : pid_remap_and_coproc_access

// [test/cp_core_model.sv]
// Behavioural core that issues coprocessor moves to the block.
`timescale 1ns/1ps
module cp_core_model (
    // Clock
    input wire logic clk,
    // Move request out, answer back
    output pid_pkg::cp_req_t req,
    input pid_pkg::cp_resp_t resp
);
    initial begin
        req = '0;
    end

    // One move per cycle; the answer is taken one falling edge later.
    task automatic move(input logic wr, input logic priv, input logic [3:0] cp,
                        input logic [3:0] crn, input logic [3:0] crm,
                        input logic [31:0] wdata, output pid_pkg::cp_resp_t ans);
        req = {1'b1, wr, priv, cp, crn, crm, pid_pkg::OP2_ZERO, wdata};
        @(negedge clk);
        ans = resp;
    endtask : move

    // Breakpoints are written already merged with the slot value.
    task automatic set_break(input logic [3:0] crm, input logic [24:0] off,
                             input logic [6:0] slot, output pid_pkg::cp_resp_t ans);
        move(1'b1, 1'b1, pid_pkg::CP_SYS, pid_pkg::CRN_BREAK, crm, {slot, off}, ans);
    endtask : set_break

    // Stale write data is inverted so a design that ignores valid shows it.
    task automatic idle();
        req.valid = 1'b0;
        req.wdata = ~req.wdata;
        @(negedge clk);
    endtask : idle
endmodule : cp_core_model

// [test/pid_remap_and_coproc_access_test.sv]
// Self-checking bench for the process slot remap and coprocessor access block.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pid_remap_and_coproc_access_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sync_point = 1'b0;
    logic [31:0] instr_va = 32'h0000_0000;
    logic [31:0] data_va = 32'h0000_0000;
    pid_pkg::cp_req_t req;
    pid_pkg::cp_resp_t resp;
    pid_pkg::cp_resp_t ans;
    pid_pkg::break_regs_t break_regs;
    logic [31:0] instr_mod_addr, data_mod_addr, branch_buf_addr, rng, w;
    logic branch_buf_flush;
    logic [13:0] perm_active, perm;
    logic [6:0] slot, old_slot;
    logic [3:0] crm_tab [5] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4};
    int err_total = 0;
    int checked = 0;

    always #2.5 clk = ~clk;

    cp_core_model u_cp_core_model (.clk(clk), .req(req), .resp(resp));
    pid_remap_and_coproc_access u_pid_remap_and_coproc_access (.clk(clk), .reset(reset),
        .req(req), .resp(resp), .sync_point(sync_point), .instr_va(instr_va),
        .data_va(data_va), .instr_mod_addr(instr_mod_addr), .data_mod_addr(data_mod_addr),
        .branch_buf_addr(branch_buf_addr), .branch_buf_flush(branch_buf_flush),
        .break_regs(break_regs), .perm_active(perm_active));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift

    function automatic logic [31:0] remap(input logic [31:0] va, input logic [6:0] s);
        return (va[31:25] == 7'h00) ? {s, va[24:0]} : va;
    endfunction : remap

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    // Staged values reach the live copies only through a sync pulse.
    task automatic pulse_sync();
        sync_point = 1'b1;
        @(negedge clk);
        sync_point = 1'b0;
        repeat (2) @(negedge clk);
    endtask : pulse_sync

    task automatic check_addr(input logic [31:0] iv, input logic [31:0] dv, input logic [6:0] s);
        instr_va = iv;
        data_va = dv;
        @(negedge clk);
        `CHK(instr_mod_addr, remap(iv, s))
        `CHK(data_mod_addr, remap(dv, s))
        `CHK(branch_buf_addr, iv)
    endtask : check_addr

    task automatic next_rng();
        rng = xorshift(rng);
    endtask : next_rng

    initial begin
        rng = 32'h7a14fcba;
        old_slot = 7'h00;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        `CHK(perm_active, 14'h0000)
        `CHK(break_regs, {160{1'b0}})
        check_addr(32'h0000_1000, 32'h0200_0000, 7'h00);
        for (int i = 0; i < 8; i++) begin
            next_rng();
            slot = (i == 0) ? 7'h7f : rng[6:0];
            u_cp_core_model.move(1'b1, 1'b1, pid_pkg::CP_SYS, pid_pkg::CRN_SLOT,
                pid_pkg::CRM_SLOT, {slot, rng[24:0]}, ans);
            `CHK(branch_buf_flush, 1'b1)
            u_cp_core_model.move(1'b0, 1'b1, pid_pkg::CP_SYS, pid_pkg::CRN_SLOT,
                pid_pkg::CRM_SLOT, 32'h0, ans);
            `CHK(ans.rdata, {slot, 25'h0})
            u_cp_core_model.idle();
            check_addr(rng & 32'h01ff_ffff, rng | 32'h8000_0000, old_slot);
            pulse_sync();
            check_addr(rng & 32'h01ff_ffff, rng | 32'h0200_0000, slot);
            old_slot = slot;
        end
        // A sync pulse right after a slot write must already carry the new value.
        slot = 7'h05;
        u_cp_core_model.move(1'b1, 1'b1, pid_pkg::CP_SYS, pid_pkg::CRN_SLOT,
            pid_pkg::CRM_SLOT, {slot, 25'h0}, ans);
        `CHK(branch_buf_flush, 1'b1)
        sync_point = 1'b1;
        u_cp_core_model.idle();
        sync_point = 1'b0;
        check_addr(32'h0000_1000, 32'hfe00_0000, slot);
        for (int r = 0; r < 4; r++) begin
            next_rng();
            w = (r == 0) ? 32'hffff_ffff : rng;
            perm = w[13:0];
            u_cp_core_model.move(1'b1, 1'b1, pid_pkg::CP_SYS, pid_pkg::CRN_PERM,
                pid_pkg::CRM_PERM, w, ans);
            u_cp_core_model.move(1'b1, 1'b0, pid_pkg::CP_SYS, pid_pkg::CRN_PERM,
                pid_pkg::CRM_PERM, 32'h0, ans);
            `CHK(ans.undef, 1'b1)
            u_cp_core_model.move(1'b0, 1'b1, pid_pkg::CP_SYS, pid_pkg::CRN_PERM,
                pid_pkg::CRM_PERM, 32'h0, ans);
            `CHK(ans.rdata, {18'h0, perm})
            u_cp_core_model.idle();
            pulse_sync();
            `CHK(perm_active, perm)
            for (int c = 0; c < 32; c++) begin
                u_cp_core_model.move(1'b0, c[4], c[3:0], rng[3:0], rng[7:4], rng, ans);
                `CHK(ans.done, 1'b1)
                `CHK(ans.undef, (c[3:0] > 4'hd) ? !c[4] : !perm[c[3:0]])
                `CHK(ans.grant, (c[3:0] <= 4'hd) && perm[c[3:0]])
            end
            u_cp_core_model.idle();
        end
        for (int k = 0; k < 5; k++) begin
            next_rng();
            u_cp_core_model.set_break(crm_tab[k], rng[24:0], slot, ans);
            u_cp_core_model.move(1'b0, 1'b1, pid_pkg::CP_SYS, pid_pkg::CRN_BREAK,
                crm_tab[k], 32'h0, ans);
            `CHK(ans.rdata, {slot, rng[24:0]})
            u_cp_core_model.idle();
            `CHK(break_regs[(4 - k) * 32 +: 32], {slot, rng[24:0]})
        end
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule : pid_remap_and_coproc_access_test
